/* core/desq_pkg.sv */
// Constants shared by the drive enable sequencer, its machine model and its test bench.
// Assumes a 40 MHz system clock and a classic Wishbone register port.
package desq_pkg;

  // Clock rate in MHz
  localparam int CLK_MHZ = 40;

  // Sampling periods and disable windows in microseconds
  localparam int SEQ_TICK_US = 4000;
  localparam int LIMIT_TICK_US = 250;
  localparam int STO_LIMIT_US = 20000;
  localparam int FAST_LIMIT_US = 600;
  localparam int LIMIT_RESP_US = 750;

  // Cycle counts derived from the times above
  localparam int SEQ_TICK_CYCLES = SEQ_TICK_US * CLK_MHZ;
  localparam int LIMIT_TICK_CYCLES = LIMIT_TICK_US * CLK_MHZ;
  localparam int STO_LIMIT_CYCLES = STO_LIMIT_US * CLK_MHZ;
  localparam int FAST_LIMIT_CYCLES = FAST_LIMIT_US * CLK_MHZ;
  localparam int LIMIT_RESP_CYCLES = LIMIT_RESP_US * CLK_MHZ;

  // Register byte offsets
  localparam logic [3:0] REG_STATUS_OFS = 4'h0;
  localparam logic [3:0] REG_SEQ_OFS = 4'h4;
  localparam logic [3:0] REG_LIMIT_OFS = 4'h8;
  localparam logic [3:0] REG_DIO_OFS = 4'hc;

  // Sequencing register fields
  localparam int SEQ_RUN_FWD_BIT = 0;
  localparam int SEQ_JOG_BIT = 1;
  localparam int SEQ_RUN_REV_BIT = 2;
  localparam int SEQ_DIR_SEL_BIT = 3;
  localparam int SEQ_RUN_BIT = 4;
  localparam int SEQ_JOG_REV_BIT = 5;
  localparam int SEQ_NOT_STOP_BIT = 6;
  localparam int SEQ_LATCH_EN_BIT = 7;
  localparam int SEQ_WIDTH = 8;
  localparam logic [7:0] SEQ_RESET = 8'h00;

  // Limit switch register fields
  localparam int LIM_FWD_BIT = 0;
  localparam int LIM_REV_BIT = 1;
  localparam logic [1:0] LIMIT_RESET = 2'h0;

  // Digital I/O configuration fields
  localparam int NUM_DIO = 6;
  localparam int DIO_INPUT_LSB = 0;
  localparam int DIO_ROUTE_LSB = 8;
  localparam int DIO_INVERT_LSB = 16;
  localparam logic [5:0] DIO_RESET = 6'h00;

  // Status register fields
  localparam int ST_ENABLE_BIT = 0;
  localparam int ST_MIRROR_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  localparam int ST_REVERSE_BIT = 3;
  localparam int ST_JOG_BIT = 4;
  localparam int ST_LIMIT_BIT = 5;
  localparam int ST_TRIP_BIT = 6;

  // Speed demand width
  localparam int SPEED_W = 16;

  // Jog sequencer states
  typedef enum logic [1:0] {JOG_IDLE, JOG_RUN_FWD, JOG_RUN_REV} desq_jog_state_type;

endpackage : desq_pkg

/* core/desq_tick_gen.sv */
// Periodic one-cycle tick generator for the sequencer sampling clocks.
// Assumes a synchronous active-high reset; CYCLES must be at least 2.
`timescale 1ns/100ps
`default_nettype none

module desq_tick_gen #(
  parameter int CYCLES = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // One-cycle tick every CYCLES clocks
  output logic tick_o
);

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  // Free running counter
  logic [CW-1:0] count;

  // Count wraps at LAST and fires the tick in the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (count == LAST);
      count <= (count == LAST) ? '0 : count + CW'(1);
    end
  end

endmodule : desq_tick_gen

`default_nettype wire

/* core/desq_top.sv */
// Drive enable status and run sequencer with a Wishbone register port.
// Assumes all pins synchronous to clk_i; speed demand is the summed pre-ramp and hard reference.
`timescale 1ns/100ps
`default_nettype none

module desq_top import desq_pkg::*; #(
  parameter int SEQ_TICK_CYC = SEQ_TICK_CYCLES,
  parameter int LIMIT_TICK_CYC = LIMIT_TICK_CYCLES,
  parameter int STO_LIMIT_CYC = STO_LIMIT_CYCLES,
  parameter int FAST_LIMIT_CYC = FAST_LIMIT_CYCLES,
  parameter int LIMIT_RESP_CYC = LIMIT_RESP_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Enable sources
  input wire logic torque_off_terminal_i,
  input wire logic [NUM_DIO-1:0] dio_in_i,
  // Trip conditions
  input wire logic ac_overcurrent_trip_i,
  input wire logic ten_volt_supply_trip_i,
  input wire logic twentyfour_volt_supply_trip_i,
  input wire logic brake_overcurrent_trip_i,
  input wire logic overvoltage_trip_i,
  // Motion state
  input wire logic signed [SPEED_W-1:0] speed_demand_i,
  input wire logic motor_stopped_i,
  // Drive outputs
  output logic gate_drive_enable_o,
  output logic enable_status_bit_o,
  output logic enable_input_mirror_o,
  output logic drive_run_o,
  output logic drive_reverse_o,
  output logic limit_stop_o
);

  // Latch one run bit: hold or set while not-stop, else clear
  function automatic logic latch_step(input logic held, input logic cmd, input logic not_stop);
    latch_step = not_stop & (held | cmd);
  endfunction : latch_step

  // Merge write data into a register under the byte enables
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    wb_merge = res;
  endfunction : wb_merge

  // Software registers
  logic [SEQ_WIDTH-1:0] seq_reg;              // Raw sequencing bits
  logic [1:0] limit_reg;                      // Raw limit switch bits
  logic [NUM_DIO-1:0] dio_input;              // Channel set as input
  logic [NUM_DIO-1:0] dio_route;              // Channel destination is enable status
  logic [NUM_DIO-1:0] dio_invert;             // Channel invert setting

  // Sampled copies and latches
  logic [SEQ_WIDTH-1:0] seq_s;                // Sequencing bits seen by the sequencer
  logic [1:0] limit_s;                        // Limit bits seen by the stop logic
  logic latch_fwd;
  logic latch_rev;
  logic latch_run;
  desq_jog_state_type jog_state;

  // Ticks
  logic tick_seq;
  logic tick_limit;

  // Sequencing sample tick
  desq_tick_gen #(.CYCLES(SEQ_TICK_CYC)) u_seq_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick_seq)
  );

  // Limit switch sample tick
  desq_tick_gen #(.CYCLES(LIMIT_TICK_CYC)) u_limit_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick_limit)
  );

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & ~wb_ack_o;
  wire [31:0] seq_word = {24'h000000, seq_reg};
  wire [31:0] limit_word = {30'h0, limit_reg};
  wire [31:0] dio_word = {8'h00, 2'h0, dio_invert, 2'h0, dio_route, 2'h0, dio_input};

  // Enable combining: channel level after invert, only for routed inputs
  wire [NUM_DIO-1:0] dio_level = dio_in_i ^ dio_invert;
  wire [NUM_DIO-1:0] fast_sel = dio_input & dio_route;
  wire fast_ok = &(~fast_sel | dio_level);
  wire trip_any = ac_overcurrent_trip_i | ten_volt_supply_trip_i | twentyfour_volt_supply_trip_i
                  | brake_overcurrent_trip_i | overvoltage_trip_i;
  wire force_off = ~fast_ok | trip_any;

  // Run command decode from the sampled bits
  wire latch_on = seq_s[SEQ_LATCH_EN_BIT];
  wire eff_fwd = latch_on ? latch_fwd : seq_s[SEQ_RUN_FWD_BIT];
  wire eff_rev = latch_on ? latch_rev : seq_s[SEQ_RUN_REV_BIT];
  wire eff_run = latch_on ? latch_run : seq_s[SEQ_RUN_BIT];
  wire normal_run = eff_fwd | eff_rev | eff_run;
  // Forward wins if a controller mixes both styles against advice
  wire normal_rev = ~eff_fwd & (eff_rev | (eff_run & seq_s[SEQ_DIR_SEL_BIT]));
  wire jog_active = (jog_state != JOG_IDLE);

  // Jog activation edges, seen at the sampling tick
  wire jog_rise = tick_seq & seq_reg[SEQ_JOG_BIT] & ~seq_s[SEQ_JOG_BIT];
  wire jog_rev_rise = tick_seq & seq_reg[SEQ_JOG_REV_BIT] & ~seq_s[SEQ_JOG_REV_BIT];
  wire jog_start_ok = motor_stopped_i & ~normal_run;

  // Limit switches apply by sign of the summed demand
  wire demand_pos = (speed_demand_i > 0);
  wire demand_neg = (speed_demand_i < 0);
  wire limit_hit = (demand_pos & limit_s[LIM_FWD_BIT]) | (demand_neg & limit_s[LIM_REV_BIT])
                   | (~demand_pos & ~demand_neg & |limit_s);

  // Read mux
  logic [31:0] read_word;
  always_comb begin
    unique case (wb_adr_i)
      REG_STATUS_OFS: read_word = {25'h0, trip_any, limit_stop_o, jog_active, drive_reverse_o,
                                   drive_run_o, enable_input_mirror_o, enable_status_bit_o};
      REG_SEQ_OFS: read_word = seq_word;
      REG_LIMIT_OFS: read_word = limit_word;
      REG_DIO_OFS: read_word = dio_word;
      default: read_word = 32'h00000000;  // Unmapped offsets read zero
    endcase
  end

  // Write data merged over the addressed word, so unselected bytes keep their value
  wire [31:0] merged_word = wb_merge(read_word, wb_dat_i, wb_sel_i);

  // Wishbone answer: one wait state, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= (bus_req & ~wb_ack_o & ~wb_we_i) ? read_word : 32'h00000000;
    end
  end

  // Register writes; status is read-only, unmapped writes ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_reg <= SEQ_RESET;
      limit_reg <= LIMIT_RESET;
      dio_input <= DIO_RESET;
      dio_route <= DIO_RESET;
      dio_invert <= DIO_RESET;
    end else if (bus_wr) begin
      if (wb_adr_i == REG_SEQ_OFS) begin
        seq_reg <= merged_word[SEQ_WIDTH-1:0];
      end
      if (wb_adr_i == REG_LIMIT_OFS) begin
        limit_reg <= merged_word[1:0];
      end
      if (wb_adr_i == REG_DIO_OFS) begin
        dio_input <= merged_word[DIO_INPUT_LSB +: NUM_DIO];
        dio_route <= merged_word[DIO_ROUTE_LSB +: NUM_DIO];
        dio_invert <= merged_word[DIO_INVERT_LSB +: NUM_DIO];
      end
    end
  end

  // Enable path: forcing acts at once, torque-off reaches status on the slow tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_status_bit_o <= 1'b0;
      gate_drive_enable_o <= 1'b0;
      enable_input_mirror_o <= 1'b0;
    end else begin
      enable_input_mirror_o <= torque_off_terminal_i;
      gate_drive_enable_o <= torque_off_terminal_i & ~force_off;
      if (force_off) begin
        enable_status_bit_o <= 1'b0;
      end else if (tick_seq) begin
        enable_status_bit_o <= torque_off_terminal_i;
      end
    end
  end

  // Sampling of the command bits on their ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_s <= SEQ_RESET;
      limit_s <= LIMIT_RESET;
    end else begin
      if (tick_seq) begin
        seq_s <= seq_reg;
      end
      if (tick_limit) begin
        limit_s <= limit_reg;
      end
    end
  end

  // Run latches follow the same tick, so they line up with seq_s
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_fwd <= 1'b0;
      latch_rev <= 1'b0;
      latch_run <= 1'b0;
    end else if (tick_seq) begin
      latch_fwd <= latch_step(latch_fwd, seq_reg[SEQ_RUN_FWD_BIT], seq_reg[SEQ_NOT_STOP_BIT]);
      latch_rev <= latch_step(latch_rev, seq_reg[SEQ_RUN_REV_BIT], seq_reg[SEQ_NOT_STOP_BIT]);
      latch_run <= latch_step(latch_run, seq_reg[SEQ_RUN_BIT], seq_reg[SEQ_NOT_STOP_BIT]);
    end
  end

  // Jog sequencer: starts only from standstill, a normal run takes over
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jog_state <= JOG_IDLE;
    end else begin
      unique case (jog_state)
        JOG_IDLE: begin
          if (jog_rise & jog_start_ok) begin
            jog_state <= JOG_RUN_FWD;
          end else if (jog_rev_rise & jog_start_ok) begin
            jog_state <= JOG_RUN_REV;
          end
        end
        JOG_RUN_FWD: begin
          if (~seq_s[SEQ_JOG_BIT] | normal_run) begin
            jog_state <= JOG_IDLE;
          end
        end
        JOG_RUN_REV: begin
          if (~seq_s[SEQ_JOG_REV_BIT] | normal_run) begin
            jog_state <= JOG_IDLE;
          end
        end
        default: jog_state <= JOG_IDLE;  // Fourth code is illegal
      endcase
    end
  end

  // Run, direction and limit stop outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_run_o <= 1'b0;
      drive_reverse_o <= 1'b0;
      limit_stop_o <= 1'b0;
    end else begin
      drive_run_o <= enable_status_bit_o & (normal_run | jog_active);
      drive_reverse_o <= normal_run ? normal_rev : (jog_state == JOG_RUN_REV);
      limit_stop_o <= limit_hit;
    end
  end

  // Helper counters that only the checks below read
  logic [31:0] sto_low_cnt;
  logic [31:0] fast_low_cnt;
  logic [31:0] limit_wait_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sto_low_cnt <= 32'h00000000;
      fast_low_cnt <= 32'h00000000;
      limit_wait_cnt <= 32'h00000000;
    end else begin
      sto_low_cnt <= torque_off_terminal_i ? 32'h00000000 : sto_low_cnt + 32'h00000001;
      fast_low_cnt <= fast_ok ? 32'h00000000 : fast_low_cnt + 32'h00000001;
      // Counts while a forward limit is set at positive demand but no stop shows
      limit_wait_cnt <= (limit_reg[LIM_FWD_BIT] & demand_pos & ~limit_stop_o)
                        ? limit_wait_cnt + 32'h00000001 : 32'h00000000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence fast_drop_s;
    fast_ok ##1 !fast_ok;
  endsequence
  sequence status_low_s;
    !enable_status_bit_o && !gate_drive_enable_o;
  endsequence

  mirror_follow_a: assert property (##1 enable_input_mirror_o == $past(torque_off_terminal_i))
    else $error("mirror does not follow enable input");
  fast_force_a: assert property (fast_drop_s |=> status_low_s)
    else $error("fast disable did not force status low");
  trip_force_a: assert property (trip_any |=> status_low_s)
    else $error("trip did not force disable");
  fast_window_a: assert property ((fast_low_cnt >= 32'(FAST_LIMIT_CYC)) |-> !enable_status_bit_o)
    else $error("fast disable window exceeded");
  sto_window_a: assert property ((sto_low_cnt >= 32'(STO_LIMIT_CYC)) |-> !enable_status_bit_o)
    else $error("torque-off disable window exceeded");
  gate_needs_both_a: assert property (gate_drive_enable_o |-> $past(torque_off_terminal_i) && $past(fast_ok))
    else $error("gate drive without both enables");
  sto_gate_a: assert property (!torque_off_terminal_i |=> !gate_drive_enable_o)
    else $error("gate drive kept after torque-off");
  status_rise_a: assert property ($rose(enable_status_bit_o) |-> $past(tick_seq) && $past(torque_off_terminal_i))
    else $error("status rose without enable input");
  stop_clears_a: assert property (tick_seq && !seq_reg[SEQ_NOT_STOP_BIT] |=> !latch_fwd && !latch_rev && !latch_run)
    else $error("latches not cleared by stop");
  latch_hold_a: assert property (latch_run && !(tick_seq && !seq_reg[SEQ_NOT_STOP_BIT]) |=> latch_run)
    else $error("run latch lost while not-stop high");
  jog_start_a: assert property ($rose(jog_active) |-> $past(motor_stopped_i) && !$past(normal_run))
    else $error("jog started while moving or running");
  limit_dir_a: assert property (demand_neg && limit_s[LIM_REV_BIT] |=> limit_stop_o)
    else $error("reverse limit ignored at negative demand");
  limit_resp_a: assert property (limit_wait_cnt < 32'(LIMIT_RESP_CYC))
    else $error("limit stop response too slow");
  seq_sample_a: assert property (!tick_seq |=> $stable(seq_s))
    else $error("sequencing bits sampled off tick");
  limit_sample_a: assert property (!tick_limit |=> $stable(limit_s))
    else $error("limit bits sampled off tick");

endmodule : desq_top

`default_nettype wire

/* verification/desq_machine_model.sv */
// Machine-side model: safe enable, fast enable and trip lines.
// Assumes the bench changes its requests just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none

module desq_machine_model import desq_pkg::*; (
  // Clock
  input wire logic clk_i,
  // Requests from the bench
  input wire logic safe_en_i,
  input wire logic fast_en_i,
  input wire logic [4:0] trip_i,
  // Lines toward the drive
  output logic torque_off_o = 1'b0,
  output logic [NUM_DIO-1:0] dio_o = '0,
  output logic [4:0] trip_o = '0
);
  // Two independent enables, so a stuck fast line cannot lift the safe one
  always @(posedge clk_i) begin
    torque_off_o <= safe_en_i;
    dio_o <= {NUM_DIO{fast_en_i}};
    trip_o <= trip_i;
  end
endmodule : desq_machine_model

`default_nettype wire

/* verification/test_drive_enable_sequencer.sv */
// Self-checking bench for the drive enable sequencer.
// Assumes shortened tick parameters; the tick and window waits derive from them.
`timescale 1ns/100ps
`default_nettype none

module test_drive_enable_sequencer import desq_pkg::*;;
  // Shortened counts
  localparam int SEQ_T = 40;
  localparam int LIM_T = 10;
  localparam int STO_T = 200;
  localparam int FAST_T = 8;
  localparam int RESP_T = 30;
  // One sequencer tick plus output stage and margin
  localparam int TW = SEQ_T + 5;
  // Bench signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic safe_en = 1'b0;
  logic fast_en = 1'b0;
  logic [4:0] trip_req = 5'h00;
  logic torque_off;
  logic [NUM_DIO-1:0] dio_in;
  logic [4:0] trip;
  logic signed [SPEED_W-1:0] speed = 16'sh0000;
  logic stopped = 1'b0;
  logic gate, status, mirror, run, rev, lstop;
  int err_total = 0;
  int tests_run = 0;
  // Sequencer table: register value and expected {reverse, run}
  logic [7:0] seqv [16] = '{8'h01, 8'h04, 8'h18, 8'h10, 8'hc1, 8'hc0, 8'h80, 8'h81, 8'h00, 8'hd0, 8'hc8, 8'h00,
                            8'h02, 8'h00, 8'h20, 8'h00};
  logic [1:0] expv [16] = '{2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h0,
                            2'h1, 2'h0, 2'h3, 2'h0};

  // Clock, 25 ns period
  always #12.5 clk_i = ~clk_i;

  // Far-side model
  desq_machine_model u_machine (.clk_i(clk_i), .safe_en_i(safe_en), .fast_en_i(fast_en), .trip_i(trip_req),
    .torque_off_o(torque_off), .dio_o(dio_in), .trip_o(trip));

  // Device under test with short ticks
  desq_top #(.SEQ_TICK_CYC(SEQ_T), .LIMIT_TICK_CYC(LIM_T), .STO_LIMIT_CYC(STO_T), .FAST_LIMIT_CYC(FAST_T),
    .LIMIT_RESP_CYC(RESP_T)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .torque_off_terminal_i(torque_off), .dio_in_i(dio_in),
    .ac_overcurrent_trip_i(trip[0]), .ten_volt_supply_trip_i(trip[1]), .twentyfour_volt_supply_trip_i(trip[2]),
    .brake_overcurrent_trip_i(trip[3]), .overvoltage_trip_i(trip[4]), .speed_demand_i(speed),
    .motor_stopped_i(stopped), .gate_drive_enable_o(gate), .enable_status_bit_o(status),
    .enable_input_mirror_o(mirror), .drive_run_o(run), .drive_reverse_o(rev), .limit_stop_o(lstop));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; waits on ack, only the watchdog ends a hang
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  // Register write
  task automatic wr(input logic [3:0] adr, input logic [31:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, adr, d, r);
  endtask : wr

  // Register read and compare
  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, adr, 32'h0, r);
    chk(r, exp);
  endtask : rd_chk

  // Wait c edges, then compare masked outputs {lstop, rev, run, mirror, status, gate}
  task automatic ochk(input int c, input logic [5:0] msk, input logic [5:0] exp);
    repeat (c) @(posedge clk_i);
    chk({26'h0, {lstop, rev, run, mirror, status, gate} & msk}, {26'h0, exp});
  endtask : ochk

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, read-only and unmapped places
    rd_chk(REG_SEQ_OFS, 32'h0);
    rd_chk(REG_LIMIT_OFS, 32'h0);
    rd_chk(REG_STATUS_OFS, 32'h0);
    wr(REG_STATUS_OFS, 32'hffffffff);
    rd_chk(REG_STATUS_OFS, 32'h0);
    rd_chk(4'h2, 32'h0);
    wr(REG_SEQ_OFS, 32'hffffffff);
    rd_chk(REG_SEQ_OFS, 32'hff);
    wr(REG_SEQ_OFS, 32'h0);
    $display("test registers finished");
    // Enable follows the inputs
    safe_en <= 1'b1;
    fast_en <= 1'b1;
    ochk(3, 6'h05, 6'h05);
    ochk(TW, 6'h07, 6'h07);
    rd_chk(REG_STATUS_OFS, 32'h3);
    $display("test enable finished");
    // Level, latched and jog commands
    stopped <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      wr(REG_SEQ_OFS, {24'h0, seqv[i]});
      ochk(TW, 6'h18, {1'b0, expv[i], 3'h0});
      // Reverse jog running: status shows jog, run, reverse, mirror and enable
      if (i == 14) begin
        rd_chk(REG_STATUS_OFS, 32'h1f);
      end
    end
    stopped <= 1'b0;
    wr(REG_SEQ_OFS, 32'h02);
    ochk(TW, 6'h08, 6'h00);
    wr(REG_SEQ_OFS, 32'h00);
    $display("test sequencing finished");
    // Each trip forces disable
    for (int i = 0; i < 5; i++) begin
      trip_req <= 5'h01 << i;
      ochk(3, 6'h03, 6'h00);
      rd_chk(REG_STATUS_OFS, 32'h42);
      trip_req <= 5'h00;
      ochk(TW, 6'h03, 6'h03);
    end
    $display("test trips finished");
    // Fast disable on channel 2, plain then inverted
    wr(REG_DIO_OFS, 32'h00000404);
    fast_en <= 1'b0;
    ochk(FAST_T, 6'h07, 6'h04);
    wr(REG_DIO_OFS, 32'h00040404);
    rd_chk(REG_DIO_OFS, 32'h00040404);
    ochk(TW, 6'h03, 6'h03);
    fast_en <= 1'b1;
    ochk(FAST_T, 6'h03, 6'h00);
    wr(REG_DIO_OFS, 32'h0);
    ochk(TW, 6'h03, 6'h03);
    $display("test fast disable finished");
    // Safe torque off: gate at once, software within its limit
    safe_en <= 1'b0;
    ochk(3, 6'h05, 6'h00);
    ochk(STO_T, 6'h07, 6'h00);
    safe_en <= 1'b1;
    ochk(TW, 6'h07, 6'h07);
    $display("test torque off finished");
    // Limit switches by sign of demand
    speed <= 16'sd100;
    wr(REG_LIMIT_OFS, 32'h1);
    ochk(RESP_T, 6'h20, 6'h20);
    speed <= -16'sd100;
    ochk(3, 6'h20, 6'h00);
    speed <= 16'sd0;
    ochk(3, 6'h20, 6'h20);
    wr(REG_LIMIT_OFS, 32'hffffffff);
    rd_chk(REG_LIMIT_OFS, 32'h3);
    wr(REG_LIMIT_OFS, 32'h2);
    speed <= 16'sd100;
    ochk(RESP_T, 6'h20, 6'h00);
    speed <= -16'sd100;
    ochk(3, 6'h20, 6'h20);
    wr(REG_LIMIT_OFS, 32'h0);
    ochk(RESP_T, 6'h20, 6'h00);
    $display("test limits finished");
    complete_run();
  end
endmodule : test_drive_enable_sequencer

`default_nettype wire
